// ### rtl/open_drain_status_gpio.sv
/*
 * open-drain status / general io port: three pins, each an input, a host-driven
 * output or an active-low status indicator, with a wishbone register view.
 * assumes status sources come from logic on i_sys_clk, and that the straps
 * (address select at mid level, lead-acid kind) are already digital levels.
 */
// Register access over Wishbone and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module open_drain_status_gpio
    import od_gpio_pkg::*;
(
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // supply and shutdown events
    input wire logic i_supply_undervolt_lockout,
    input wire logic i_shutdown_pin,
    input wire logic i_micropower_shutdown,
    // straps
    input wire logic i_address_select_mid,
    input wire logic i_sealed_lead_acid,
    // status sources
    input wire status_src_t i_status,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // open-drain pins
    input wire logic [NUM_PINS-1:0] i_pin,
    output logic [NUM_PINS-1:0] o_pin,
    output logic [NUM_PINS-1:0] o_pin_oe
);

    pin_cfg_t cfg;
    logic backup_fault_flag;
    logic no_host;
    logic strap_pending;
    logic [NUM_PINS-1:0] pin_meta;
    logic [NUM_PINS-1:0] pin_sync;
    logic [NUM_PINS-1:0] next_pull_low;
    logic charging_indicator_n;
    logic taper_reached_n;
    logic backup_fault_n;
    logic charge_fault_n;
    logic calibration_done_n;
    logic pin1_status_n;
    logic pin3_status_n;
    logic cfg_reset;
    logic wr_cycle;
    bus_state_t bus_state;

    // lockout or shutdown are the only sources of configuration reset
    assign cfg_reset = i_supply_undervolt_lockout | i_shutdown_pin;
    assign wr_cycle = i_wb_cyc & i_wb_stb & i_wb_we & (bus_state == ST_IDLE);

    function automatic logic lane_hit(input logic [7:0] adr, input logic [7:0] ofs);
        lane_hit = (adr[7:2] == ofs[7:2]);
    endfunction

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta <= 3'h0;
            pin_sync <= 3'h0;
        end else begin
            pin_meta <= i_pin;
            pin_sync <= pin_meta;
        end
    end

    // strap is caught on the first clocked edge after reset or config reset
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            strap_pending <= 1'b1;
            no_host <= 1'b0;
        end else if (cfg_reset) begin
            strap_pending <= 1'b1;
        end else if (strap_pending) begin
            strap_pending <= 1'b0;
            no_host <= i_address_select_mid;
        end
    end

    // pin configuration registers
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cfg.en <= EN_RESET;
            cfg.out_val <= OUT_RESET;
            cfg.sel <= SEL_RESET;
        end else if (cfg_reset) begin
            cfg.en <= EN_RESET;
            cfg.out_val <= OUT_RESET;
            cfg.sel <= SEL_RESET;
        end else if (strap_pending && i_address_select_mid) begin
            cfg.en <= FORCED_ONES;
            cfg.sel <= FORCED_ONES;
        end else if (wr_cycle && lane_hit(i_wb_adr, PIN_CTRL_OFS)) begin
            if (i_wb_sel[0]) begin
                cfg.en <= i_wb_dat[EN_LSB +: 3];
                cfg.out_val <= i_wb_dat[OUT_LSB +: 3];
            end
            if (i_wb_sel[1]) begin
                cfg.sel <= i_wb_dat[SEL_LSB +: 3];
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            backup_fault_flag <= 1'b0;
        end else if (i_status.backup_fault_event) begin
            backup_fault_flag <= 1'b1;
        end else if (cfg_reset) begin
            backup_fault_flag <= 1'b0;
        end else if (wr_cycle && lane_hit(i_wb_adr, BACKUP_CONTROL_OFS) && i_wb_sel[0]
                     && i_wb_dat[FAULT_CLEAR_BIT]) begin
            backup_fault_flag <= 1'b0;
        end
    end
    // fault flag feeds only the pin 2 indicator and its status register bit, nothing inhibits charging here

    assign charging_indicator_n = ~(i_status.charge_phase_bit0 | i_status.charge_phase_bit1);
    assign taper_reached_n = ~i_status.taper_reached;
    assign backup_fault_n = ~backup_fault_flag;
    assign charge_fault_n = ~i_status.charge_fault_flag;
    assign calibration_done_n = ~i_status.calibration_done_out;

    assign pin1_status_n = i_sealed_lead_acid ? taper_reached_n : charging_indicator_n;
    assign pin3_status_n = no_host ? charge_fault_n : calibration_done_n;

    always_comb begin
        next_pull_low = 3'h0;
        if (cfg.en[0]) begin
            next_pull_low[0] = cfg.sel[0] ? ~pin1_status_n : ~cfg.out_val[0];
        end
        if (cfg.en[1]) begin
            next_pull_low[1] = cfg.sel[1] ? ~backup_fault_n : ~cfg.out_val[1];
        end
        if (cfg.en[2]) begin
            next_pull_low[2] = cfg.sel[2] ? ~pin3_status_n : ~cfg.out_val[2];
        end
        if (i_micropower_shutdown) begin
            next_pull_low = 3'h0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pin <= 3'h0;
            o_pin_oe <= 3'h0;
        end else begin
            o_pin <= 3'h0;
            o_pin_oe <= next_pull_low;
        end
    end

    // wishbone slave: one-cycle ack, dropped the cycle after
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            bus_state <= ST_IDLE;
            o_wb_ack <= 1'b0;
            o_wb_dat <= UNMAPPED_READ;
        end else begin
            unique case (bus_state)
                ST_IDLE: begin
                    o_wb_ack <= 1'b0;
                    if (i_wb_cyc && i_wb_stb) begin
                        bus_state <= ST_ACK;
                        o_wb_ack <= 1'b1;
                        o_wb_dat <= UNMAPPED_READ;
                        if (lane_hit(i_wb_adr, PIN_CTRL_OFS)) begin
                            o_wb_dat[EN_LSB +: 3] <= cfg.en;
                            o_wb_dat[OUT_LSB +: 3] <= cfg.out_val;
                            o_wb_dat[SEL_LSB +: 3] <= cfg.sel;
                        end else if (lane_hit(i_wb_adr, BACKUP_STATUS_OFS)) begin
                            o_wb_dat[IN_LSB +: 3] <= pin_sync;
                            o_wb_dat[BACKUP_FAULT_BIT] <= backup_fault_flag;
                            o_wb_dat[CHARGE_FAULT_BIT] <= i_status.charge_fault_flag;
                            o_wb_dat[NO_HOST_BIT] <= no_host;
                        end else if (lane_hit(i_wb_adr, SOURCE_STATUS_OFS)) begin
                            o_wb_dat[5:0] <= i_status;
                        end
                    end
                end
                ST_ACK: begin
                    o_wb_ack <= 1'b0;
                    bus_state <= ST_IDLE;
                end
                // unused codes fall back to idle
                default: begin
                    o_wb_ack <= 1'b0;
                    bus_state <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ### include/od_gpio_pkg.sv
/*
 * constants and types for the open-drain status/io port block.
 * assumes a 32-bit classic wishbone slave view of the registers.
 */
package od_gpio_pkg;

    localparam int NUM_PINS = 3;

    // register byte offsets
    localparam logic [7:0] PIN_CTRL_OFS = 8'h00;
    localparam logic [7:0] BACKUP_STATUS_OFS = 8'h04;
    localparam logic [7:0] BACKUP_CONTROL_OFS = 8'h08;
    localparam logic [7:0] SOURCE_STATUS_OFS = 8'h0c;

    // pin control field positions (per pin: enable, out value, status select)
    localparam int EN_LSB = 0;
    localparam int OUT_LSB = 4;
    localparam int SEL_LSB = 8;

    // backup status field positions
    localparam int IN_LSB = 0;
    localparam int BACKUP_FAULT_BIT = 4;
    localparam int CHARGE_FAULT_BIT = 5;
    localparam int NO_HOST_BIT = 6;

    // backup control fields
    localparam int FAULT_CLEAR_BIT = 0;

    // reset values and the no-host strap value
    localparam logic [2:0] EN_RESET = 3'h0;
    localparam logic [2:0] OUT_RESET = 3'h0;
    localparam logic [2:0] SEL_RESET = 3'h0;
    localparam logic [2:0] FORCED_ONES = 3'h7;

    localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

    typedef struct packed {
        logic [2:0] en;
        logic [2:0] out_val;
        logic [2:0] sel;
    } pin_cfg_t;

    typedef struct packed {
        logic charge_phase_bit1;
        logic charge_phase_bit0;
        logic taper_reached;
        logic backup_fault_event;
        logic charge_fault_flag;
        logic calibration_done_out;
    } status_src_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ACK = 2'b01
    } bus_state_t;

endpackage

// ### tb/od_pullup_model.sv
/* pull-up resistors and an external sinking device on the three pins.
   assumes the port drives its pins open-drain through the enables. */
`timescale 1ns/1ps
module od_pullup_model (
    // drivers
    input wire logic [2:0] i_oe,
    input wire logic [2:0] i_ext_low,
    // wire levels
    output logic [2:0] o_level
);
    assign o_level = ~(i_oe | i_ext_low);
endmodule

// ### tb/od_gpio_sva.sv
/* bus and pin checks for the open-drain port.
   assumes one clock domain and the top module's ports only. */
`timescale 1ns/1ps
module od_gpio_sva
    import od_gpio_pkg::*;
(
    // clock, reset, events
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_supply_undervolt_lockout,
    input wire logic i_shutdown_pin,
    input wire logic i_micropower_shutdown,
    // bus
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // pins
    input wire logic [NUM_PINS-1:0] o_pin,
    input wire logic [NUM_PINS-1:0] o_pin_oe
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    wire cfg_rst = i_supply_undervolt_lockout | i_shutdown_pin;
    a_sink_only: assert property (o_pin == '0)
        else $error("pin data not low");
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_ack_follows: assert property ($rose(i_wb_stb) && i_wb_cyc |=> o_wb_ack)
        else $error("no ack after request");
    a_ack_cause: assert property (!(i_wb_cyc && i_wb_stb) |=> !o_wb_ack)
        else $error("ack without request");
    a_sleep_release: assert property (i_micropower_shutdown |=> o_pin_oe == '0)
        else $error("pin driven in shutdown");
    a_cfg_reset_pins: assert property (cfg_rst [*2] |=> o_pin_oe == '0)
        else $error("pin driven in config reset");
    a_ctrl_locked: assert property ($rose(i_wb_stb) && !i_wb_we && i_wb_adr == 8'h00
        && cfg_rst && $past(cfg_rst) |=> o_wb_dat == '0)
        else $error("config not cleared");
    a_unmapped_zero: assert property ($rose(i_wb_stb) && !i_wb_we
        && i_wb_adr > 8'h0f |=> o_wb_dat == '0)
        else $error("unmapped read not zero");
    cover property ($rose(i_micropower_shutdown));
    cover property (cfg_rst [*2]);
    cover property (o_wb_ack && i_wb_we);
endmodule
bind open_drain_status_gpio od_gpio_sva u_sva (.i_sys_clk, .i_rst_n,
    .i_supply_undervolt_lockout, .i_shutdown_pin, .i_micropower_shutdown, .i_wb_cyc,
    .i_wb_stb, .i_wb_we, .i_wb_adr, .o_wb_dat, .o_wb_ack, .o_pin, .o_pin_oe);

// ### tb/tb.sv
/* self-checking bench: wishbone driver, queued read results.
   assumes the pull-up model on the pins. */
`timescale 1ns/1ps
module tb;
    import od_gpio_pkg::*;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, supply_undervolt_lockout = 1'b0, shutdown_pin = 1'b0, mps = 1'b0;
    logic mid = 1'b0, sealed_lead_acid = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ff = 1'b0, nh = 1'b0;
    logic [3:0] sel = 4'hf;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0, rdat;
    logic [2:0] lvl, oe, ext_low = 3'h0;
    status_src_t st = '0;
    logic [31:0] expq[$];
    int n_fail = 0, checks = 0;
    always #4 i_sys_clk = ~i_sys_clk;
    open_drain_status_gpio u_dut (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
        .i_supply_undervolt_lockout(supply_undervolt_lockout), .i_shutdown_pin(shutdown_pin), .i_micropower_shutdown(mps),
        .i_address_select_mid(mid), .i_sealed_lead_acid(sealed_lead_acid), .i_status(st), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .i_pin(lvl), .o_pin(), .o_pin_oe(oe));
    od_pullup_model u_pull (.i_oe(oe), .i_ext_low(ext_low), .o_level(lvl));
    task automatic conclude();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    function automatic logic [31:0] exp_bs(input logic [31:0] c);
        logic [2:0] s;
        logic [2:0] low;
        s = {nh ? st.charge_fault_flag : st.calibration_done_out, ff,
             sealed_lead_acid ? st.taper_reached : st.charge_phase_bit0 | st.charge_phase_bit1};
        low = mps ? 3'h0 : c[2:0] & ((c[10:8] & s) | (~c[10:8] & ~c[6:4]));
        return {25'h0, nh, st.charge_fault_flag, ff, 1'b0, ~(low | ext_low)};
    endfunction
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        @(posedge i_sys_clk);
        while (ack !== 1'b1) begin
            i++;
            if (i > 50) begin
                n_fail++;
                $display("CHECK FAILED t=%0t no ack", $time);
                conclude();
            end
            @(posedge i_sys_clk);
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge i_sys_clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expq.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask
    task automatic look(input logic [31:0] c);
        repeat (4) @(posedge i_sys_clk);
        rd(BACKUP_STATUS_OFS, exp_bs(c));
    endtask
    always @(posedge i_sys_clk) begin
        if (ack === 1'b1 && we === 1'b0 && expq.size() > 0) begin
            chk(rdat, expq.pop_front());
        end
    end
    initial begin
        logic [31:0] c;
        int k;
        k = $urandom(32'hcdca);
        repeat (20) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        @(posedge i_sys_clk);
        rd(PIN_CTRL_OFS, 32'h0);
        look(32'h0);
        rd(8'h10, 32'h0);
        $display("defaults done");
        for (k = 0; k < 16; k++) begin
            c = $urandom & 32'h777;
            st <= status_src_t'(6'($urandom));
            ext_low <= 3'($urandom);
            sealed_lead_acid <= 1'($urandom);
            bus(1'b1, PIN_CTRL_OFS, c);
            ff = ff | st.backup_fault_event;
            rd(PIN_CTRL_OFS, c);
            look(c);
        end
        st <= status_src_t'(6'h04);
        repeat (2) @(posedge i_sys_clk);
        st <= '0;
        ff = 1'b1;
        look(c);
        bus(1'b1, BACKUP_CONTROL_OFS, 32'h1);
        ff = 1'b0;
        look(c);
        $display("modes done");
        for (k = 0; k < 2; k++) begin
            supply_undervolt_lockout <= (k == 0);
            shutdown_pin <= (k == 1);
            repeat (2) @(posedge i_sys_clk);
            bus(1'b1, PIN_CTRL_OFS, 32'h777);
            rd(PIN_CTRL_OFS, 32'h0);
            supply_undervolt_lockout <= 1'b0;
            shutdown_pin <= 1'b0;
            @(posedge i_sys_clk);
            rd(PIN_CTRL_OFS, 32'h0);
            bus(1'b1, PIN_CTRL_OFS, 32'h777);
        end
        bus(1'b1, PIN_CTRL_OFS, 32'h007);
        mps <= 1'b1;
        look(32'h007);
        mps <= 1'b0;
        $display("resets done");
        mid <= 1'b1;
        i_rst_n <= 1'b0;
        @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        st <= status_src_t'(6'h0a);
        nh = 1'b1;
        @(posedge i_sys_clk);
        rd(PIN_CTRL_OFS, 32'h707);
        look(32'h707);
        bus(1'b1, PIN_CTRL_OFS, 32'h070);
        rd(PIN_CTRL_OFS, 32'h070);
        look(32'h070);
        repeat (2) @(posedge i_sys_clk);
        chk(32'(expq.size()), 32'h0);
        $display("no-host done");
        conclude();
    end
endmodule
